//--- hw/eim_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - dedicated vector is map nibble then 0010
// - map nibble zero is never delivered
// - pending holds eight pin and two timer bits
// - each dedicated source has its own mask bit
// - timer requests are always dedicated sources
// - expanded mode vector is inverted pins, pin0 LSB
// - expanded pins are always low-level, debounced
// - expanded vectors 0 to 7 are ignored
// - expanded: pins 7-4 to map0, 3-0 latched
// - expanded: mask bit 0 gates all expanded
// - expanded: pin pending bits never post
// - mixed: pins 4-0 plus 010; pins 7-5 dedicated
// - mixed: pins 4-1 to map0, pin0 latched
// - mixed: mask 0 expanded, mask 7-5 pins
// - service copies mask to may clear
// - mask clear choice: none, ded, exp, all
// - equal vectors from both kinds count expanded
// - mask never reloaded copy
// - two-bit control field selects pin mode
// - falling edge posts pending; service clears it
// - debounce needs seven consecutive low samples
// - pins sampled once every two clocks
module eim_top
  import eim_pkg::*;
(
  input wire logic clock,
  input wire logic ce,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] ext_request_pins_n,
  input wire logic [1:0] timer_unit_requests,
  input wire logic core_service,
  output logic int_valid,
  output logic [7:0] int_vector,
  output logic [4:0] int_priority,
  output logic int_expanded,
  output logic [15:0] saved_mask_r3,
  output logic saved_mask_strobe
);
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] din,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = din[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  eim_pin_if pif ();

  eim_sampler u_sampler (
    .clock(clock),
    .ce(ce),
    .rst_n(rst_n),
    .ext_request_pins_n(ext_request_pins_n),
    .pins(pif.smp)
  );

  logic [13:0] request_control_reg;
  logic [15:0] request_mask_reg;
  logic [15:0] request_pending_reg;
  logic [15:0] vector_map_regs [EIM_NMAP];
  logic [3:0] xlow;
  logic [7:0] prev_act;
  logic [3:0] win_src;

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire wr_pnd = wr && hit(wb_adr_i, EIM_OFS_PND);
  wire wr_msk = wr && hit(wb_adr_i, EIM_OFS_MSK);
  wire wr_ctl = wr && hit(wb_adr_i, EIM_OFS_CTL);
  wire [2:0] wr_map = {wr && hit(wb_adr_i, EIM_OFS_MAP2),
                       wr && hit(wb_adr_i, EIM_OFS_MAP1),
                       wr && hit(wb_adr_i, EIM_OFS_MAP0)};

  // Control fields
  wire [1:0] mode = request_control_reg[EIM_CTL_MODE +: 2];
  wire is_exp = (mode == EIM_MODE_EXP);
  wire is_mix = (mode == EIM_MODE_MIX);
  wire [7:0] det_edge = request_control_reg[EIM_CTL_DET +: 8];
  wire gie = request_control_reg[EIM_CTL_GIE];
  wire use_deb = request_control_reg[EIM_CTL_DEB];
  wire [1:0] mop = request_control_reg[EIM_CTL_MOP +: 2];

  // Which pins act as dedicated inputs in the current mode
  wire [7:0] role_ded = is_exp ? 8'h00 :
                        is_mix ? EIM_MIX_DED_PINS : 8'hFF;
  wire [7:0] act = use_deb ? pif.deb_act : pif.fast_act;

  // Posting: level follows the pin, edge catches a fresh assertion
  wire [7:0] pin_set = {8{pif.tick}} & role_ded &
                       ((det_edge & act & ~prev_act) |
                        (~det_edge & act));
  wire [15:0] hw_set = {2'b00, timer_unit_requests, 4'h0, pin_set};

  // Source view: 0-7 pins, 8-9 timers
  wire [9:0] src_pnd = {request_pending_reg[EIM_TMR_BIT +: 2],
                        request_pending_reg[7:0]};
  wire [9:0] src_msk = {request_mask_reg[EIM_TMR_BIT +: 2],
                        request_mask_reg[7:0]};
  wire [9:0] src_ded = {2'b11, role_ded};
  wire [7:0] dvec [EIM_NSRC];

  genvar s;
  generate
    for (s = 0; s < EIM_NSRC; s++) begin : g_vec
      assign dvec[s] = {vector_map_regs[s/4][4*(s%4) +: 4],
                        EIM_VEC_LOW_DED};
    end
  endgenerate

  logic [7:0] best_vec;
  logic [3:0] best_src;
  logic best_ok;
  always_comb begin
    best_vec = 8'h00;
    best_src = 4'h0;
    best_ok = 1'b0;
    for (int k = 0; k < EIM_NSRC; k++) begin
      if (src_pnd[k] && !src_msk[k] && src_ded[k] &&
          dvec[k][7:4] != 4'h0 &&
          dvec[k] > best_vec) begin
        best_vec = dvec[k];
        best_src = 4'(k);
        best_ok = 1'b1;
      end
    end
  end

  // Expanded vector rebuilt from the internal buffers
  wire [7:0] xvec = is_exp ?
                    {vector_map_regs[0][3:0], xlow} :
                    {vector_map_regs[0][3:0], xlow[0],
                     EIM_VEC_LOW_MIX};
  wire x_ok = (is_exp || is_mix) && !request_mask_reg[0] &&
              xvec > EIM_VEC_IGN_MAX;
  // Ties go to the expanded source
  wire use_x = x_ok && (!best_ok || xvec >= best_vec);

  wire svc = core_service && int_valid;
  wire clr_m = svc && ((mop == EIM_MOP_ALL) ||
                       (mop == EIM_MOP_DED && !int_expanded) ||
                       (mop == EIM_MOP_EXP && int_expanded));
  wire [15:0] svc_clr = (svc && !int_expanded) ?
                        (win_src >= 4'h8 ?
                         16'h0001 << (EIM_TMR_BIT + win_src - 4'h8) :
                         16'h0001 << win_src) : 16'h0000;

  wire next_valid = gie && !svc && (use_x || best_ok);
  wire [7:0] next_vec = use_x ? xvec : best_vec;

  wire [31:0] wm = wmerge(32'h0, wb_dat_i, wb_sel_i);
  wire [31:0] msk_merge = wmerge({16'h0, request_mask_reg}, wb_dat_i,
                                 wb_sel_i);
  wire [31:0] pnd_merge = wmerge({16'h0, request_pending_reg}, wb_dat_i,
                                 wb_sel_i);
  wire [31:0] ctl_merge = wmerge({18'h0, request_control_reg}, wb_dat_i,
                                 wb_sel_i);
  wire [15:0] next_msk = wr_msk ? msk_merge[15:0] : request_mask_reg;
  wire [15:0] pnd_base = wr_pnd ? pnd_merge[15:0] : request_pending_reg;
  // Hardware set beats any clear in the same cycle
  wire [15:0] next_pnd = ((pnd_base & ~svc_clr) | hw_set) & EIM_PND_IMPL;

  wire [31:0] stat = {17'h0, int_expanded, int_valid, int_priority,
                      int_vector[7:0]};
  wire [31:0] rd_data =
    hit(wb_adr_i, EIM_OFS_PND) ? {16'h0, request_pending_reg} :
    hit(wb_adr_i, EIM_OFS_MSK) ? {16'h0, request_mask_reg} :
    hit(wb_adr_i, EIM_OFS_CTL) ? {18'h0, request_control_reg} :
    hit(wb_adr_i, EIM_OFS_MAP0) ? {16'h0, vector_map_regs[0]} :
    hit(wb_adr_i, EIM_OFS_MAP1) ? {16'h0, vector_map_regs[1]} :
    hit(wb_adr_i, EIM_OFS_MAP2) ? {16'h0, vector_map_regs[2]} :
    hit(wb_adr_i, EIM_OFS_SAVE) ? {16'h0, saved_mask_r3} :
    hit(wb_adr_i, EIM_OFS_STAT) ? stat : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      request_control_reg <= EIM_CTL_RST;
      request_pending_reg <= 16'h0000;
      prev_act <= 8'h00;
    end else if (ce) begin
      if (wr_ctl) begin
        request_control_reg <= ctl_merge[13:0];
      end
      request_pending_reg <= next_pnd;
      if (pif.tick) begin
        prev_act <= act;
      end
    end
  end

  // A serviced request saves the mask; it is never restored here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      request_mask_reg <= EIM_MSK_RST;
      saved_mask_r3 <= 16'h0000;
      saved_mask_strobe <= 1'b0;
    end else if (ce) begin
      saved_mask_strobe <= svc;
      if (svc) begin
        saved_mask_r3 <= request_mask_reg;
      end
      request_mask_reg <= clr_m ? 16'h0000 : next_msk;
    end
  end

  // Expanded buffers reuse the low nibble of map 0
  genvar m;
  generate
    for (m = 0; m < EIM_NMAP; m++) begin : g_map
      wire cap = (m == 0) && pif.tick && (is_exp || is_mix);
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          vector_map_regs[m] <= EIM_MAP_RST;
        end else if (ce) begin
          if (wr_map[m]) begin
            vector_map_regs[m] <= wm[15:0] |
              (vector_map_regs[m] & ~{{8{wb_sel_i[1]}},
                                      {8{wb_sel_i[0]}}});
          end
          if (cap) begin
            vector_map_regs[m][3:0] <= is_exp ? pif.deb_act[7:4] :
                                       pif.deb_act[4:1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xlow <= 4'h0;
    end else if (ce && pif.tick) begin
      if (is_exp) begin
        xlow <= pif.deb_act[3:0];
      end else if (is_mix) begin
        xlow <= {3'h0, pif.deb_act[0]};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_valid <= 1'b0;
      int_vector <= 8'h00;
      int_priority <= 5'h00;
      int_expanded <= 1'b0;
      win_src <= 4'h0;
    end else if (ce) begin
      int_valid <= next_valid;
      int_vector <= next_vec;
      int_priority <= next_vec[7:3];
      int_expanded <= use_x;
      win_src <= best_src;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  bus_ack_a: assert property (
    ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ded_low_a: assert property (
    int_valid && !int_expanded |-> int_vector[3:0] == EIM_VEC_LOW_DED)
    else $error("dedicated vector low nibble wrong");
  nib_zero_a: assert property (
    int_valid && !int_expanded |-> int_vector[7:4] != 4'h0)
    else $error("undefined vector delivered");
  low_vec_a: assert property (
    int_valid |-> int_vector > EIM_VEC_IGN_MAX)
    else $error("vector 0 to 7 delivered");
  exp_mask_a: assert property (
    ce && request_mask_reg[0] |=> !(int_valid && int_expanded))
    else $error("masked expanded request delivered");
  save_mask_a: assert property (
    ce && svc |=> saved_mask_strobe &&
    saved_mask_r3 == $past(request_mask_reg))
    else $error("mask not copied on service");
  clear_all_a: assert property (
    ce && svc && mop == EIM_MOP_ALL |=> request_mask_reg == 16'h0000)
    else $error("mask not cleared on service");
  keep_mask_a: assert property (
    ce && svc && mop == EIM_MOP_NONE && !wr_msk |=>
    $stable(request_mask_reg))
    else $error("mask changed with clearing off");
  timer_post_a: assert property (
    ce && timer_unit_requests[0] |=> request_pending_reg[EIM_TMR_BIT])
    else $error("timer request not posted");
  exp_nopost_a: assert property (
    ce && is_exp && !wr_pnd && request_pending_reg[7:0] == 8'h00 |=>
    request_pending_reg[7:0] == 8'h00)
    else $error("pin pending posted in expanded mode");
endmodule

//--- hw/eim_pkg.sv
package eim_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] EIM_OFS_PND = 8'h00;
  localparam logic [7:0] EIM_OFS_MSK = 8'h04;
  localparam logic [7:0] EIM_OFS_CTL = 8'h10;
  localparam logic [7:0] EIM_OFS_MAP0 = 8'h20;
  localparam logic [7:0] EIM_OFS_MAP1 = 8'h24;
  localparam logic [7:0] EIM_OFS_MAP2 = 8'h28;
  localparam logic [7:0] EIM_OFS_SAVE = 8'h30;
  localparam logic [7:0] EIM_OFS_STAT = 8'h34;

  localparam int EIM_NPIN = 8;
  localparam int EIM_NSRC = 10;
  localparam int EIM_NMAP = 3;

  // Control register fields
  localparam int EIM_CTL_W = 14;
  localparam int EIM_CTL_MODE = 0;
  localparam int EIM_CTL_DET = 2;
  localparam int EIM_CTL_GIE = 10;
  localparam int EIM_CTL_DEB = 11;
  localparam int EIM_CTL_MOP = 12;
  localparam logic [13:0] EIM_CTL_RST = 14'h0000;

  // Pending and mask layout: pins in bits 7:0, timers in bits 13:12
  localparam int EIM_TMR_BIT = 12;
  localparam logic [15:0] EIM_PND_IMPL = 16'h30FF;
  localparam logic [15:0] EIM_MSK_RST = 16'h0000;
  localparam logic [15:0] EIM_MAP_RST = 16'h0000;

  // Mode field encodings; the spare code falls back to dedicated
  localparam logic [1:0] EIM_MODE_DED = 2'h0;
  localparam logic [1:0] EIM_MODE_EXP = 2'h1;
  localparam logic [1:0] EIM_MODE_MIX = 2'h2;

  // Mask-clear-on-service encodings
  localparam logic [1:0] EIM_MOP_NONE = 2'h0;
  localparam logic [1:0] EIM_MOP_DED = 2'h1;
  localparam logic [1:0] EIM_MOP_EXP = 2'h2;
  localparam logic [1:0] EIM_MOP_ALL = 2'h3;

  // Vector encodings
  localparam logic [3:0] EIM_VEC_LOW_DED = 4'h2;
  localparam logic [2:0] EIM_VEC_LOW_MIX = 3'h2;
  localparam logic [7:0] EIM_VEC_IGN_MAX = 8'h07;
  localparam logic [7:0] EIM_MIX_DED_PINS = 8'hE0;

  // Pin sampling
  localparam int EIM_SAMPLE_DIV = 2;
  localparam logic [2:0] EIM_DEB_SAMPLES = 3'h7;
endpackage

//--- hw/eim_pin_if.sv
`timescale 1ns/1ps
interface eim_pin_if;
  logic tick;
  logic [7:0] fast_act;
  logic [7:0] deb_act;
  modport smp (output tick, output fast_act, output deb_act);
  modport core (input tick, input fast_act, input deb_act);
endinterface

//--- hw/eim_sampler.sv
`timescale 1ns/1ps
module eim_sampler
  import eim_pkg::*;
(
  input wire logic clock,
  input wire logic ce,
  input wire logic rst_n,
  input wire logic [7:0] ext_request_pins_n,
  eim_pin_if.smp pins
);
  logic phase;
  logic [7:0] fast_q;
  logic [7:0] deb_q;

  // Pins are looked at only on every second clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= 1'b0;
    end else if (ce) begin
      phase <= ~phase;
    end
  end

  assign pins.tick = phase;
  assign pins.fast_act = fast_q;
  assign pins.deb_act = deb_q;

  genvar i;
  generate
    for (i = 0; i < EIM_NPIN; i++) begin : g_pin
      logic [2:0] cnt;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          cnt <= 3'h0;
          fast_q[i] <= 1'b0;
          deb_q[i] <= 1'b0;
        end else if (ce && phase) begin
          fast_q[i] <= ~ext_request_pins_n[i];
          if (!ext_request_pins_n[i]) begin
            // Counter saturates so a long low holds the filtered level
            if (cnt != EIM_DEB_SAMPLES - 3'h1) begin
              cnt <= cnt + 3'h1;
            end
            deb_q[i] <= (cnt == EIM_DEB_SAMPLES - 3'h1);
          end else begin
            cnt <= 3'h0;
            deb_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  tick_period_a: assert property (
    ce && phase |=> !phase)
    else $error("sample tick held for two cycles");
  deb_seven_a: assert property (
    $rose(deb_q[0]) |-> $past(g_pin[0].cnt) == EIM_DEB_SAMPLES - 3'h1)
    else $error("debounce asserted before seven low samples");
endmodule

//--- sim/eim_src_model.sv
`timescale 1ns/1ps
// External encoder and dedicated sources on the far side of the pins
module eim_src_model (
  input wire logic clock,
  input wire logic [1:0] mode,
  input wire logic [7:0] ded_low,
  input wire logic [7:0] vec,
  input wire logic load,
  input wire logic clr,
  output logic [7:0] ext_request_pins_n
);
  logic [7:0] held;
  // Winner is held until software clears the source
  always_ff @(posedge clock) begin
    if (clr) begin
      held <= 8'h00;
    end else if (load) begin
      held <= vec;
    end
  end
  // Vector zero (all pins high) means nothing pending
  assign ext_request_pins_n = (mode == 2'h1) ? ~held :
    (mode == 2'h2) ? ~{ded_low[7:5], held[7:3]} : ~ded_low;
endmodule

//--- sim/test_eim_top.sv
`timescale 1ns/1ps
module test_eim_top;
  import eim_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, core_service = 1'b0, int_valid, int_expanded, strobe;
  logic [1:0] tmr = 2'h0, mode = 2'h0;
  logic [7:0] pins_n, ded_low = 8'h00, vec = 8'h00, int_vector;
  logic load = 1'b0, clr = 1'b1;
  logic [4:0] int_priority;
  logic [15:0] r3;
  int mismatches = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  eim_top dut_u (.clock(clock), .ce(1'b1), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_request_pins_n(pins_n), .timer_unit_requests(tmr),
    .core_service(core_service), .int_valid(int_valid),
    .int_vector(int_vector), .int_priority(int_priority),
    .int_expanded(int_expanded), .saved_mask_r3(r3),
    .saved_mask_strobe(strobe));
  eim_src_model src_u (.clock(clock), .mode(mode), .ded_low(ded_low),
    .vec(vec), .load(load), .clr(clr), .ext_request_pins_n(pins_n));
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    rdat = dat_o;
    if (n == 20) chk(32'h0, 32'h1, "no ack");
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string w);
    bus(1'b0, a, 32'h0);
    chk(rdat, e, w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_valid(input logic [7:0] v, input logic x);
    int n;
    for (n = 0; n < 80 && int_valid !== 1'b1; n++) @(posedge clock);
    #1;
    chk({23'h0, int_valid, int_vector}, {23'h1, v}, "vector");
    chk({26'h0, int_expanded, int_priority}, {26'h0, x, v[7:3]}, "kind");
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk({31'h0, int_valid}, 32'h0, "spurious request");
    end
  endtask
  task automatic service(input logic [15:0] m);
    @(posedge clock);
    core_service <= 1'b1;
    @(posedge clock);
    core_service <= 1'b0;
    #1;
    chk({15'h0, strobe, r3}, {15'h1, m}, "saved mask");
  endtask
  task automatic t_reset();
    rd(EIM_OFS_PND, 32'h0, "pnd");
    rd(EIM_OFS_MSK, 32'h0, "msk");
    rd(EIM_OFS_CTL, 32'h0, "ctl");
    rd(EIM_OFS_MAP0, 32'h0, "map0");
    rd(8'h3C, 32'h0, "unmapped");
  endtask
  task automatic t_timer();
    bus(1'b1, EIM_OFS_MAP2, 32'h5);
    bus(1'b1, EIM_OFS_MSK, 32'h2000);
    bus(1'b1, EIM_OFS_CTL, 32'h1400);
    @(posedge clock) tmr <= 2'h1;
    @(posedge clock) tmr <= 2'h0;
    idle(1);
    #1 chk({31'h0, int_valid}, 32'h1, "timer valid");
    wait_valid(8'h52, 1'b0);
    service(16'h2000);
    rd(EIM_OFS_MSK, 32'h0, "ded clear");
    rd(EIM_OFS_PND, 32'h0, "pnd clear");
    bus(1'b1, EIM_OFS_MAP2, 32'h0);
    // Timer left unmasked so only the zero nibble can hold it back
    bus(1'b1, EIM_OFS_MSK, 32'h0);
    @(posedge clock) tmr <= 2'h1;
    @(posedge clock) tmr <= 2'h0;
    quiet(20);
    bus(1'b1, EIM_OFS_PND, 32'h0);
  endtask
  task automatic t_edge();
    bus(1'b1, EIM_OFS_MAP0, 32'h700);
    bus(1'b1, EIM_OFS_MSK, 32'h8);
    bus(1'b1, EIM_OFS_CTL, 32'h0413);
    @(posedge clock) ded_low <= 8'h04;
    idle(6);
    ded_low <= 8'h00;
    wait_valid(8'h72, 1'b0);
    service(16'h0008);
    rd(EIM_OFS_MSK, 32'h8, "none keeps");
    rd(EIM_OFS_PND, 32'h0, "edge cleared");
  endtask
  task automatic t_exp();
    bus(1'b1, EIM_OFS_MSK, 32'h2000);
    bus(1'b1, EIM_OFS_CTL, 32'h2401);
    @(posedge clock) begin
      mode <= 2'h1; vec <= 8'h9A; load <= 1'b1;
    end
    @(posedge clock) load <= 1'b0;
    quiet(8);
    wait_valid(8'h9A, 1'b1);
    rd(EIM_OFS_MAP0, 32'h709, "exp map0");
    rd(EIM_OFS_PND, 32'h0, "exp pnd");
    service(16'h2000);
    rd(EIM_OFS_MSK, 32'h0, "exp clear");
    bus(1'b1, EIM_OFS_MSK, 32'h1);
    quiet(20);
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
    // Let the buffered vector drain before the mask opens again
    idle(6);
    bus(1'b1, EIM_OFS_MSK, 32'h0);
    @(posedge clock) begin
      vec <= 8'h05; load <= 1'b1;
    end
    @(posedge clock) load <= 1'b0;
    quiet(40);
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
  endtask
  task automatic t_mix();
    bus(1'b1, EIM_OFS_MSK, 32'h80);
    bus(1'b1, EIM_OFS_CTL, 32'h3402);
    @(posedge clock) begin
      mode <= 2'h2; vec <= 8'h98; load <= 1'b1;
    end
    @(posedge clock) load <= 1'b0;
    wait_valid(8'h9A, 1'b1);
    rd(EIM_OFS_MAP0, 32'h709, "mix map0");
    service(16'h0080);
    rd(EIM_OFS_MSK, 32'h0, "all clear");
    // Pin 7 and the expanded inputs both ask for vector 0x92
    bus(1'b1, EIM_OFS_MSK, 32'h40);
    bus(1'b1, EIM_OFS_CTL, 32'h2402);
    bus(1'b1, EIM_OFS_MAP1, 32'h9000);
    @(posedge clock) begin
      vec <= 8'h90; load <= 1'b1; ded_low <= 8'h80;
    end
    @(posedge clock) load <= 1'b0;
    idle(40);
    wait_valid(8'h92, 1'b1);
    service(16'h0040);
    rd(EIM_OFS_MSK, 32'h0, "tie clear");
  endtask
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    idle(3);
    rst_n <= 1'b1;
    clr <= 1'b0;
    t_reset();
    t_timer();
    t_edge();
    t_exp();
    t_mix();
    conclude();
  end
endmodule
